// ==== hdl/dsu_pkg.sv ====
/*
 * constants, register offsets and types shared by both ends of the display
 * status, pixel packing and waveform select block.
 * assumes one clock (clk_sys_i, 25 MHz) and a synchronous active-high reset.
 */
`default_nettype none
package dsu_pkg;
    // register indices (byte address = 4 x index on the avalon side)
    localparam logic [7:0] DSU_REG_CAL      = 8'h29;
    localparam logic [7:0] DSU_REG_TSEL     = 8'h40;
    localparam logic [7:0] DSU_REG_TVAL     = 8'h41;
    localparam logic [7:0] DSU_REG_STATUS   = 8'h50;
    localparam logic [7:0] DSU_REG_CTRL     = 8'h51;
    localparam logic [7:0] DSU_REG_PIXEL    = 8'h52;
    localparam logic [7:0] DSU_REG_WAVE     = 8'h53;
    localparam logic [7:0] DSU_REG_SENSOR   = 8'h54;
    localparam logic [7:0] DSU_REG_RTIMER   = 8'h55;
    localparam logic [7:0] DSU_REG_TEMP     = 8'h56;
    localparam logic [7:0] DSU_REG_TICKDIV  = 8'h57;

    // reset values
    localparam logic [7:0] DSU_CAL_RST      = 8'h33;
    localparam logic [7:0] DSU_TSEL_RST     = 8'h00;
    localparam logic [7:0] DSU_TVAL_RST     = 8'h18;
    localparam logic [7:0] DSU_RTIMER_RST   = 8'h64;
    localparam logic [1:0] DSU_ROT_RST      = 2'h1;
    localparam logic [7:0] DSU_SENSOR_RST   = 8'h00;

    // status byte fields
    localparam int DSU_ST_SLEEP   = 0;
    localparam int DSU_ST_SCR_LO  = 1;
    localparam int DSU_ST_AUTO    = 3;
    localparam int DSU_ST_DEPTH   = 4;

    // control register fields (write)
    localparam int DSU_CT_SLEEP   = 0;
    localparam int DSU_CT_DEPTH   = 1;
    localparam int DSU_CT_AUTO    = 2;
    localparam int DSU_CT_INVERT  = 3;
    localparam int DSU_CT_SWRST   = 4;
    localparam int DSU_CT_START   = 5;
    localparam int DSU_CT_ABORT   = 6;
    localparam int DSU_CT_SHOW    = 7;
    localparam int DSU_CT_ROT_LO  = 8;

    // refresh tick: calibration x slow clock period x 4096
    localparam int         DSU_TICK_MULT    = 4096;
    localparam int         DSU_SLOW_DIV     = 357; // 25 MHz / ~70 kHz

    // screen status codes
    typedef enum logic [1:0] {
        DSU_SCR_NONE    = 2'h0,
        DSU_SCR_LOADED  = 2'h1,
        DSU_SCR_SHOWN   = 2'h2,
        DSU_SCR_ABORTED = 2'h3
    } dsu_scr_t;

    // gray codes
    localparam logic [1:0] DSU_GRAY_BLACK = 2'h0;
    localparam logic [1:0] DSU_GRAY_WHITE = 2'h3;

    typedef enum logic [3:0] {
        DSU_UPD_IDLE = 4'b0001,
        DSU_UPD_LOAD = 4'b0010,
        DSU_UPD_CMP  = 4'b0100,
        DSU_UPD_DONE = 4'b1000
    } dsu_upd_t;
endpackage
`default_nettype wire

// ==== hdl/dsu_if.sv ====
/*
 * link between the display controller end and the host end.
 * assumes both ends on clk_sys_i; no tristate is modelled, the byte path
 * is split into a request side and an answer side.
 */
`default_nettype none
interface dsu_if;
    logic       req;      // host request strobe, one cycle
    logic       wr;       // 1 write, 0 read
    logic [7:0] addr;     // register index
    logic [7:0] wdata;    // write byte
    logic       ack;      // device answer, one cycle
    logic [7:0] rdata;    // read byte, valid with ack
    logic       hw_rst_n; // hardware reset line, active low

    modport dev  (input req, wr, addr, wdata, hw_rst_n, output ack, rdata);
    modport host (output req, wr, addr, wdata, hw_rst_n, input ack, rdata);
endinterface
`default_nettype wire

// ==== hdl/dsu_host.sv ====
/*
 * host end: avalon-mm slave for software, forwards each access as one
 * link request and waits for the device answer.
 * assumes the device answers every request; byte address = 4 x index.
 */
`default_nettype none
module dsu_host (
    input  wire logic        clk_sys_i,      // 25 MHz clock
    input  wire logic        rst_i,          // sync reset, active high
    input  wire logic [9:0]  avs_address_i,  // byte address
    input  wire logic        avs_read_i,     // read request
    input  wire logic        avs_write_i,    // write request
    input  wire logic [31:0] avs_writedata_i,// write data
    output logic      [31:0] avs_readdata_o, // read data
    output logic             avs_waitrequest_o, // stall
    input  wire logic        hw_reset_n_i,   // board reset button, active low
    dsu_if.host              link            // link to the device
);
    import dsu_pkg::*;

    logic busy_reg;
    logic done_reg;

    // one link request per avalon access; waitrequest drops for one cycle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_reg          <= 1'b0;
            done_reg          <= 1'b0;
            link.req          <= 1'b0;
            link.wr           <= 1'b0;
            link.addr         <= 8'h00;
            link.wdata        <= 8'h00;
            avs_readdata_o    <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
        end else begin
            link.req          <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            done_reg          <= 1'b0;
            if (!busy_reg && !done_reg && (avs_read_i || avs_write_i)) begin
                busy_reg   <= 1'b1;
                link.req   <= 1'b1;
                link.wr    <= avs_write_i;
                link.addr  <= avs_address_i[9:2];
                link.wdata <= avs_writedata_i[7:0];
            end else if (busy_reg && link.ack) begin
                busy_reg          <= 1'b0;
                done_reg          <= 1'b1;
                avs_readdata_o    <= {24'h00_0000, link.rdata};
                avs_waitrequest_o <= 1'b0;
            end
        end
    end

    // synchronised board reset forwarded as the hardware reset line
    logic hr_s1_reg;
    logic hr_s2_reg;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hr_s1_reg     <= 1'b1;
            hr_s2_reg     <= 1'b1;
            link.hw_rst_n <= 1'b1;
        end else begin
            hr_s1_reg     <= hw_reset_n_i;
            hr_s2_reg     <= hr_s1_reg;
            link.hw_rst_n <= hr_s2_reg;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/dsu_device.sv ====
/*
 * display controller end: status byte, pixel packing, waveform choice,
 * refresh tick, temperature override and the three-way reset.
 * assumes the host end issues one request at a time and waits for ack.
 */
// Added by the designer: the Avalon-MM register port.
// Notes on behaviour
// - tick = calibration x slow period x 4096
// - override select bit 0 picks override temperature
// - override temperature signed byte, reset 0x18
// - status request returns one assembled byte
// - status bit 0 shows sleep mode
// - status bits 2:1 give screen state
// - status bit 3 shows auto refresh
// - status bit 4 is 1 for 2-bit depth
// - status bits 7:5 read zero
// - binary byte: first pixel in D7
// - gray byte: first pixel in D7:D6
// - codes 00 black to 11 white
// - any gray transition forces slow waveform
// - only black-white changes pick fast waveform
// - only changing pixels affect the choice
// - power-on, hardware and software resets identical
// - reset: normal, binary, portrait, positive, auto, 5 min
// - pointers live in sram, no init needed
// - calibration chosen for three second ticks
// - refresh timer reload default 0x64
// - temperature sampled per display sequence
`default_nettype none
module dsu_device (
    input  wire logic        clk_sys_i,    // 25 MHz clock
    input  wire logic        rst_i,        // power-on reset, active high
    input  wire logic [7:0]  sensor_temp_i,// temperature from sensor logic
    dsu_if.dev               link,         // link to the host
    output logic             fast_bw_flow_update_o, // fast waveform chosen
    output logic             refresh_due_o,  // refresh pending
    output logic [7:0]       temperature_o,  // temperature for this sequence
    output logic [1:0]       rotation_o,     // rotation mode
    output logic             invert_o        // negative image
);
    import dsu_pkg::*;

    // reset merge: pin synchronised, all three sources same effect
    logic hr_s1_reg;
    logic hr_s2_reg;
    logic swrst_reg;
    logic rst_all;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hr_s1_reg <= 1'b1;
            hr_s2_reg <= 1'b1;
        end else begin
            hr_s1_reg <= link.hw_rst_n;
            hr_s2_reg <= hr_s1_reg;
        end
    end
    assign rst_all = rst_i || !hr_s2_reg || swrst_reg;

    logic       wr_hit;
    assign wr_hit = link.req && link.wr;

    // configuration registers
    logic [7:0] cal_reg;
    logic [7:0] tsel_reg;
    logic [7:0] tval_reg;
    logic [7:0] reload_reg;
    logic       sleep_reg;
    logic       depth2_reg;
    logic       auto_reg;
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            cal_reg    <= DSU_CAL_RST;
            tsel_reg   <= DSU_TSEL_RST;
            tval_reg   <= DSU_TVAL_RST;
            reload_reg <= DSU_RTIMER_RST;
            sleep_reg  <= 1'b0;
            depth2_reg <= 1'b0;
            auto_reg   <= 1'b1;
            rotation_o <= DSU_ROT_RST;
            invert_o   <= 1'b0;
        end else if (wr_hit) begin
            unique case (link.addr)
                DSU_REG_CAL:    cal_reg    <= link.wdata;
                DSU_REG_TSEL:   tsel_reg   <= link.wdata;
                DSU_REG_TVAL:   tval_reg   <= link.wdata;
                DSU_REG_RTIMER: reload_reg <= link.wdata;
                DSU_REG_CTRL: begin
                    sleep_reg  <= link.wdata[DSU_CT_SLEEP];
                    depth2_reg <= link.wdata[DSU_CT_DEPTH];
                    auto_reg   <= link.wdata[DSU_CT_AUTO];
                    invert_o   <= link.wdata[DSU_CT_INVERT];
                end
                DSU_REG_WAVE:   rotation_o <= link.wdata[1:0];
                default: ;
            endcase
        end
    end

    // software reset: one-cycle pulse fed back into the merge
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || swrst_reg)
            swrst_reg <= 1'b0;
        else
            swrst_reg <= wr_hit && link.addr == DSU_REG_CTRL && link.wdata[DSU_CT_SWRST];
    end

    // refresh tick: slow clock from divider, then cal x 4096 slow periods
    logic [8:0]  slow_div_reg;
    logic [11:0] sub_reg;
    logic [7:0]  cal_cnt_reg;
    logic        tick;
    logic        slow_en;
    assign slow_en = slow_div_reg == 9'(DSU_SLOW_DIV - 1);
    assign tick    = slow_en && sub_reg == 12'(DSU_TICK_MULT - 1) && cal_cnt_reg >= cal_reg - 8'h01;
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            slow_div_reg <= 9'h000;
            sub_reg      <= 12'h000;
            cal_cnt_reg  <= 8'h00;
        end else begin
            slow_div_reg <= slow_en ? 9'h000 : slow_div_reg + 9'h001;
            if (slow_en) begin
                sub_reg <= sub_reg + 12'h001;
                if (sub_reg == 12'(DSU_TICK_MULT - 1))
                    cal_cnt_reg <= tick ? 8'h00 : cal_cnt_reg + 8'h01;
            end
        end
    end

    // refresh countdown in ticks; paused while auto refresh is off
    dsu_upd_t   upd_reg;
    dsu_scr_t   scr_reg;
    logic [7:0] rtimer_reg;
    logic       rt_wr;
    logic       expire;
    assign rt_wr  = wr_hit && link.addr == DSU_REG_RTIMER;
    assign expire = tick && auto_reg && rtimer_reg == 8'h00 && !rt_wr;
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            rtimer_reg <= DSU_RTIMER_RST;
        end else if (rt_wr) begin
            rtimer_reg <= link.wdata;
        end else if (tick && auto_reg) begin
            rtimer_reg <= (rtimer_reg == 8'h00) ? reload_reg : rtimer_reg - 8'h01;
        end
    end

    // due flag: an expiry in the same cycle as an update end wins
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            refresh_due_o <= 1'b0;
        end else if (expire) begin
            refresh_due_o <= 1'b1;
        end else if (upd_reg == DSU_UPD_DONE) begin
            refresh_due_o <= 1'b0;
        end
    end

    // update machine: pixel bytes streamed in, compared against old bytes
    logic [7:0] old_reg;
    logic       gray_seen_reg;
    logic       new_hit;
    logic       grayish;
    assign new_hit = wr_hit && link.addr == DSU_REG_PIXEL;

    // per pixel slot: changing pixel touching a mid gray is slow
    logic [3:0] gray_chg;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pix
            logic [1:0] pn;
            logic [1:0] po;
            // gray: slot n is bits [7-2n:6-2n]; binary bytes are not decoded here
            assign pn = link.wdata[7 - 2 * gi -: 2];
            assign po = old_reg[7 - 2 * gi -: 2];
            assign gray_chg[gi] = (pn != po)
                && ((pn != DSU_GRAY_BLACK && pn != DSU_GRAY_WHITE)
                 || (po != DSU_GRAY_BLACK && po != DSU_GRAY_WHITE));
        end
    endgenerate
    // binary bytes hold only black or white per bit, never a gray move
    assign grayish = depth2_reg && |gray_chg;

    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            upd_reg               <= DSU_UPD_IDLE;
            scr_reg               <= DSU_SCR_NONE;
            old_reg               <= 8'h00;
            gray_seen_reg         <= 1'b0;
            fast_bw_flow_update_o <= 1'b1;
            temperature_o         <= DSU_SENSOR_RST;
        end else begin
            unique case (upd_reg)
                DSU_UPD_IDLE: if (wr_hit && link.addr == DSU_REG_CTRL
                                  && link.wdata[DSU_CT_START]) begin
                    upd_reg       <= DSU_UPD_LOAD;
                    gray_seen_reg <= 1'b0;
                end
                DSU_UPD_LOAD: begin
                    if (new_hit) begin
                        gray_seen_reg <= gray_seen_reg | grayish;
                        old_reg       <= link.wdata;
                    end else if (wr_hit && link.addr == DSU_REG_CTRL) begin
                        if (link.wdata[DSU_CT_ABORT]) begin
                            upd_reg <= DSU_UPD_IDLE;
                            scr_reg <= DSU_SCR_ABORTED;
                        end else if (link.wdata[DSU_CT_SHOW]) begin
                            upd_reg <= DSU_UPD_CMP;
                            scr_reg <= DSU_SCR_LOADED;
                        end
                    end
                end
                DSU_UPD_CMP: begin
                    fast_bw_flow_update_o <= !gray_seen_reg;
                    temperature_o <= tsel_reg[0] ? tval_reg : sensor_temp_i;
                    upd_reg <= DSU_UPD_DONE;
                end
                DSU_UPD_DONE: begin
                    scr_reg <= DSU_SCR_SHOWN;
                    upd_reg <= DSU_UPD_IDLE;
                end
            endcase
        end
    end

    // status byte assembly
    logic [7:0] status;
    assign status = {3'h0, depth2_reg, auto_reg, scr_reg, sleep_reg};

    // read answer, one cycle after the request
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            link.ack   <= 1'b0;
            link.rdata <= 8'h00;
        end else begin
            link.ack <= link.req;
            if (link.req && !link.wr) begin
                unique case (link.addr)
                    DSU_REG_CAL:    link.rdata <= cal_reg;
                    DSU_REG_TSEL:   link.rdata <= tsel_reg;
                    DSU_REG_TVAL:   link.rdata <= tval_reg;
                    DSU_REG_STATUS: link.rdata <= status;
                    DSU_REG_RTIMER: link.rdata <= rtimer_reg;
                    DSU_REG_TEMP:   link.rdata <= temperature_o;
                    DSU_REG_WAVE:   link.rdata <= {6'h00, rotation_o};
                    default:        link.rdata <= 8'h00;
                endcase
            end
        end
    end
    // pointers kept in external memory are untouched here
endmodule
`default_nettype wire

// ==== dv/dsu_link_checker.sv ====
/*
 * checker watching the link between host end and device end.
 * assumes one clock, sync active-high reset, device ack one cycle after req.
 */
`default_nettype none
module dsu_link_checker
    import dsu_pkg::*;
(
    input wire logic       clk_sys_i, // system clock
    input wire logic       rst_i,     // sync reset, active high
    input wire logic       req,       // host request strobe
    input wire logic       wr,        // 1 write, 0 read
    input wire logic [7:0] addr,      // register index
    input wire logic [7:0] wdata,     // write byte
    input wire logic       ack,       // device answer
    input wire logic [7:0] rdata,     // read byte
    input wire logic       hw_rst_n   // hardware reset line
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cal_reg;
    logic [7:0] tsel_reg;
    logic [7:0] tval_reg;
    logic       fresh_reg;
    logic       any_rst;
    logic       rd_of;

    // software reset restores the same defaults as the other two resets
    assign any_rst = rst_i || !hw_rst_n ||
                     (req && wr && addr == DSU_REG_CTRL && wdata[DSU_CT_SWRST]);

    always_ff @(posedge clk_sys_i) begin
        if (any_rst) begin
            cal_reg  <= DSU_CAL_RST;
            tsel_reg <= DSU_TSEL_RST;
            tval_reg <= DSU_TVAL_RST;
        end else if (req && wr) begin
            if (addr == DSU_REG_CAL) cal_reg <= wdata;
            if (addr == DSU_REG_TSEL) tsel_reg <= wdata;
            if (addr == DSU_REG_TVAL) tval_reg <= wdata;
        end
    end

    // status stays at its default until the first control write
    always_ff @(posedge clk_sys_i) begin
        if (any_rst) begin
            fresh_reg <= 1'b1;
        end else if (req && wr && addr == DSU_REG_CTRL) begin
            fresh_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    chk_ack_follows_req: assert property (req |=> ack)
        else $error("request not answered next cycle");
    chk_ack_has_cause: assert property (ack |-> $past(req))
        else $error("answer without request");
    chk_one_answer: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    chk_no_req_on_ack: assert property (ack |-> !req)
        else $error("request overlaps answer");
    chk_status_reserved: assert property (ack && !$past(wr) && $past(addr) == DSU_REG_STATUS
        |-> rdata[7:5] == 3'h0)
        else $error("reserved status bits set");
    chk_status_default: assert property (ack && !$past(wr) && $past(addr) == DSU_REG_STATUS
        && fresh_reg |-> rdata == 8'h08)
        else $error("status not at reset default");
    chk_cal_value: assert property (ack && !$past(wr) && $past(addr) == DSU_REG_CAL
        |-> rdata == cal_reg)
        else $error("calibration readback wrong");
    chk_tsel_value: assert property (ack && !$past(wr) && $past(addr) == DSU_REG_TSEL
        |-> rdata == tsel_reg)
        else $error("override select readback wrong");
    chk_tval_value: assert property (ack && !$past(wr) && $past(addr) == DSU_REG_TVAL
        |-> rdata == tval_reg)
        else $error("override value readback wrong");
endmodule
`default_nettype wire

// ==== dv/display_status_update_select_bench.sv ====
/*
 * bench joining host end and device end over the link; drives avalon-mm.
 * assumes byte address = 4 x index and one access at a time.
 */
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module display_status_update_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dsu_pkg::*;

    logic        clk_sys_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read    = 1'b0;
    logic        avs_write   = 1'b0;
    logic [31:0] avs_wdata   = 32'h0;
    logic        hw_reset_n  = 1'b1;
    logic [7:0]  sensor_temp = 8'h00;
    logic [31:0] avs_rdata;
    logic        avs_wait;
    logic        fast_wave;
    logic [7:0]  temp_out;
    logic [1:0]  rot_out;
    logic        inv_out;
    logic        ref_due;
    int          err_total = 0;
    int          cmp_count = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    dsu_if i_dsu_if ();
    dsu_host i_dsu_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_wdata),
        .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait),
        .hw_reset_n_i(hw_reset_n), .link(i_dsu_if.host));
    dsu_device i_dsu_device (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .sensor_temp_i(sensor_temp), .link(i_dsu_if.dev),
        .fast_bw_flow_update_o(fast_wave), .refresh_due_o(ref_due), .temperature_o(temp_out),
        .rotation_o(rot_out), .invert_o(inv_out));
    dsu_link_checker i_dsu_link_checker (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .req(i_dsu_if.req), .wr(i_dsu_if.wr), .addr(i_dsu_if.addr), .wdata(i_dsu_if.wdata),
        .ack(i_dsu_if.ack), .rdata(i_dsu_if.rdata), .hw_rst_n(i_dsu_if.hw_rst_n));

    task automatic close_out;
        $display("counts: compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // holds the request until waitrequest is sampled low, then releases
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        @(posedge clk_sys_i);
        avs_address <= {idx, 2'b00};
        avs_read    <= !w;
        avs_write   <= w;
        avs_wdata   <= {24'h000000, d};
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys_i);
            if (avs_wait === 1'b0) break;
        end
        if (n == 50) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, 1'b1, 1'b0);
            close_out();
        end
        q = avs_rdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, idx, d, q);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] q;
        acc(1'b0, idx, 8'h00, q);
        `CHK(q, e);
    endtask

    task automatic defaults;
        rdc(DSU_REG_CAL, DSU_CAL_RST);
        rdc(DSU_REG_TSEL, DSU_TSEL_RST);
        rdc(DSU_REG_TVAL, DSU_TVAL_RST);
        rdc(DSU_REG_STATUS, 8'h08);
        rdc(DSU_REG_RTIMER, DSU_RTIMER_RST);
        `CHK(rot_out, DSU_ROT_RST);
        `CHK(inv_out, 1'b0);
        `CHK(fast_wave, 1'b1);
        `CHK(ref_due, 1'b0);
    endtask

    // mode bits ride along on every control write, so they are resent each time
    task automatic upd(input logic [7:0] mode, input logic [7:0] pix);
        wr(DSU_REG_CTRL, mode | 8'h20);
        wr(DSU_REG_PIXEL, pix);
        wr(DSU_REG_CTRL, mode | 8'h80);
        rdc(DSU_REG_STATUS, {3'h0, mode[1], mode[2], 2'h2, mode[0]});
    endtask

    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        defaults();
        $display("done: defaults");
        wr(8'h3F, 8'hA5);
        rdc(8'h3F, 8'h00);
        wr(DSU_REG_CAL, 8'h5A);
        wr(DSU_REG_TSEL, 8'h01);
        wr(DSU_REG_TVAL, 8'hE7);
        rdc(DSU_REG_CAL, 8'h5A);
        rdc(DSU_REG_TSEL, 8'h01);
        rdc(DSU_REG_TVAL, 8'hE7);
        $display("done: registers");
        wr(DSU_REG_CTRL, 8'h0B);
        rdc(DSU_REG_STATUS, 8'h11);
        `CHK(inv_out, 1'b1);
        wr(DSU_REG_CTRL, 8'h24);
        wr(DSU_REG_CTRL, 8'h44);
        rdc(DSU_REG_STATUS, 8'h0E);
        $display("done: status");
        upd(8'h06, 8'h5F);
        `CHK(fast_wave, 1'b0);
        `CHK(temp_out, 8'hE7);
        // 11 to 00 moves only, unchanged pixels stay dark gray
        upd(8'h06, 8'h50);
        `CHK(fast_wave, 1'b1);
        upd(8'h06, 8'h90);
        `CHK(fast_wave, 1'b0);
        wr(DSU_REG_TSEL, 8'h00);
        sensor_temp <= 8'h2C;
        upd(8'h04, 8'hA5);
        `CHK(fast_wave, 1'b1);
        `CHK(temp_out, 8'h2C);
        $display("done: update");
        wr(DSU_REG_CTRL, 8'h10);
        repeat (4) @(posedge clk_sys_i);
        defaults();
        wr(DSU_REG_CAL, 8'h77);
        wr(DSU_REG_TVAL, 8'h80);
        hw_reset_n <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        hw_reset_n <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        defaults();
        $display("done: resets");
        close_out();
    end
endmodule
`default_nettype wire
